// >>> sqk_pkg.sv
// package for the spi port with its enable/disable behaviour
// assumes a single core clock domain plus a link clock from the master
package sqk_pkg;
  localparam int unsigned DATA_W     = 8;     // default word width
  localparam logic [7:0]  RESET_WORD = 8'h00; // data register reset value
  localparam logic [3:0]  CNT_ZERO   = 4'h0;  // bit counter start
  // core side transmit state
  typedef enum logic [1:0] {SQK_IDLE, SQK_LOAD, SQK_WAIT} sqk_state_type;
endpackage

// >>> sqk_spi_port.sv
// spi port: master and slave shift engines with control/status as plain ports
// assumes sck_i arrives from an external master in slave mode; in master mode the
// port drives its own serial clock from core_clk_i by a divider.
// the soft reset reaches only the core side; link side toggles keep their level.
// a link frame cut by a soft reset keeps its partial word until select rises.
//
// Notes on behaviour
// - keep-select plus fault detection blocks any start of a held word in either mode
// - slave mode ignores disable; port stays active
// - writes to transmit holding discarded while disabled
// - disable and discarded write keep empty flag
// - dma writes while disabled are lost
`timescale 1ns/1ps
`default_nettype none
module sqk_spi_port #(
  parameter int unsigned DATA_W = sqk_pkg::DATA_W,
  parameter int unsigned DIV_W  = 4
) (
  // clocks and reset
  input  wire logic              core_clk_i,
  input  wire logic              rstn_i,
  input  wire logic              sck_i,          // link clock in slave mode
  // control command register strobes
  input  wire logic              enable_cmd_i,
  input  wire logic              disable_cmd_i,
  input  wire logic              soft_reset_command_i,
  // mode configuration
  input  wire logic              master_mode_i,
  input  wire logic              fault_detect_disable_i,
  input  wire logic              keep_select_after_transfer_i,
  input  wire logic [DIV_W-1:0]  clk_div_i,
  // transmit holding register write (software or dma)
  input  wire logic              thr_wr_i,
  input  wire logic [DATA_W-1:0] thr_data_i,
  // receive read strobe
  input  wire logic              rx_rd_i,
  // serial pins
  input  wire logic              sel_n_i,        // slave select in slave mode
  input  wire logic              mosi_i,
  input  wire logic              miso_i,
  output logic                   sck_o,
  output logic                   mosi_o,
  output logic                   miso_o,
  output logic                   cs0_n_o,
  // status
  output logic                   enabled_o,
  output logic                   transmit_holding_empty_flag_o,
  output logic                   rx_full_o,
  output logic [DATA_W-1:0]      rx_data_o,
  output logic                   busy_o
);
  localparam int unsigned CNT_W = $clog2(DATA_W) + 1;

  // decode shared by the master start and the slave hand-over
  // a held word may move on: port on, word waiting, starts not blocked
  function automatic logic word_ready(input logic en, input logic empty, input logic ok);
    word_ready = en && !empty && ok;
  endfunction

  // port state
  logic                  enabled;       // port enable
  logic                  the_flag;      // transmit holding empty
  logic [DATA_W-1:0]     thr;           // transmit holding register
  logic [DATA_W-1:0]     rx_data;       // received word
  logic                  rx_full;       // received word unread
  sqk_pkg::sqk_state_type state;        // core side slave load state

  // master engine
  logic [DATA_W-1:0]     m_shift;
  logic [CNT_W-1:0]      m_cnt;
  logic [DIV_W-1:0]      m_div;
  logic                  m_sck;
  logic                  m_busy;
  logic                  m_cs;          // select asserted

  // slave engine, sck domain
  logic [DATA_W-1:0]     s_shift;
  logic [CNT_W-1:0]      s_cnt;
  logic [DATA_W-1:0]     s_word;        // captured word, held stable
  logic                  s_done_tgl;    // event toggle to core
  logic [DATA_W-1:0]     s_tx;          // word being sent
  logic                  s_miso;

  // slave load handshake: core offers word, sck side acknowledges
  logic                  load_req;      // core domain toggle
  logic [DATA_W-1:0]     load_word;     // stable while request open
  logic                  s_req_m, s_req_s, s_ack;
  logic                  c_ack_m, c_ack_s;
  logic                  c_done_m, c_done_s, c_done_d;

  // transfer start permission; the hang is kept on purpose
  logic                  start_ok;
  logic                  start_m;
  logic                  m_tick;
  logic                  thr_accept;
  logic                  rst_all;

  assign rst_all    = !rstn_i || soft_reset_command_i;
  // hang condition: keep-select with fault detection on never starts
  assign start_ok   = !(keep_select_after_transfer_i && !fault_detect_disable_i);
  assign start_m    = master_mode_i && !m_busy && word_ready(enabled, the_flag, start_ok);
  assign m_tick     = (m_div == clk_div_i);
  // writes while disabled are filtered; dma words then vanish
  assign thr_accept = thr_wr_i && enabled;

  // enable control; slave mode ignores disable
  // a slave stays on until a soft reset, so a lost disable cannot stop a frame
  always_ff @(posedge core_clk_i) begin
    if (rst_all) begin
      enabled <= 1'b0;
    end else if (enable_cmd_i) begin
      enabled <= 1'b1;
    end else if (disable_cmd_i && master_mode_i) begin
      enabled <= 1'b0;
    end
  end

  // transmit holding register and its empty flag
  // an accepted write beats a start in the same cycle, so no word is lost
  always_ff @(posedge core_clk_i) begin
    if (rst_all) begin
      thr      <= sqk_pkg::RESET_WORD[DATA_W-1:0];
      the_flag <= 1'b1;
    end else if (thr_accept) begin
      thr      <= thr_data_i;
      the_flag <= 1'b0; // disabled writes never reach here
    end else if (start_m || (state == sqk_pkg::SQK_LOAD)) begin
      the_flag <= 1'b1; // disable alone leaves flag untouched
    end
  end

  // master engine on core clock with divider
  always_ff @(posedge core_clk_i) begin
    if (rst_all) begin
      m_shift <= '0;
      m_cnt   <= '0;
      m_div   <= '0;
      m_sck   <= 1'b0;
      m_busy  <= 1'b0;
      m_cs    <= 1'b0;
    end else if (start_m) begin
      m_shift <= thr;
      m_cnt   <= CNT_W'(DATA_W);
      m_div   <= '0;
      m_busy  <= 1'b1;
      m_cs    <= 1'b1;
    end else if (m_busy) begin
      m_div <= m_tick ? '0 : m_div + 1'b1;
      if (m_tick) begin
        m_sck <= !m_sck;
        if (m_sck) begin
          // falling edge: shift out next bit
          m_shift <= {m_shift[DATA_W-2:0], 1'b0};
          m_cnt   <= m_cnt - 1'b1;
          if (m_cnt == CNT_W'(1)) begin
            m_busy <= 1'b0;
            m_cs   <= keep_select_after_transfer_i;
          end
        end
      end
    end else if (!keep_select_after_transfer_i) begin
      m_cs <= 1'b0;
    end
  end

  // core side: offer slave words to the link side
  // the holding register is copied out only once the link side can take it
  always_ff @(posedge core_clk_i) begin
    if (rst_all) begin
      state     <= sqk_pkg::SQK_IDLE;
      load_word <= '0;
    end else begin
      case (state)
        sqk_pkg::SQK_IDLE: begin
          if (!master_mode_i && word_ready(enabled, the_flag, start_ok)) begin
            state <= sqk_pkg::SQK_LOAD;
          end
        end
        sqk_pkg::SQK_LOAD: begin
          load_word <= thr;
          state     <= sqk_pkg::SQK_WAIT;
        end
        sqk_pkg::SQK_WAIT: begin
          if (c_ack_s == load_req) begin
            state <= sqk_pkg::SQK_IDLE;
          end
        end
        default: state <= sqk_pkg::SQK_IDLE;
      endcase
    end
  end

  // request toggle towards the link side; only the port reset clears it,
  // since clearing one end of a toggle pair on a soft reset would fake an event
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      load_req <= 1'b0;
    end else if (!soft_reset_command_i && (state == sqk_pkg::SQK_LOAD)) begin
      load_req <= !load_req;
    end
  end

  // two-flop synchronisers for the link side toggles
  // the third flop keeps the last level so a change shows once
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      c_ack_m  <= 1'b0;
      c_ack_s  <= 1'b0;
      c_done_m <= 1'b0;
      c_done_s <= 1'b0;
      c_done_d <= 1'b0;
    end else begin
      c_ack_m  <= s_ack;
      c_ack_s  <= c_ack_m;
      c_done_m <= s_done_tgl;
      c_done_s <= c_done_m;
      c_done_d <= c_done_s;
    end
  end

  // receive register; master samples miso, slave words cross by toggle
  // miso returns on our own serial clock, so it is sampled without synchronisers
  always_ff @(posedge core_clk_i) begin
    if (rst_all) begin
      rx_data <= sqk_pkg::RESET_WORD[DATA_W-1:0];
      rx_full <= 1'b0;
    end else if (m_busy && m_tick && !m_sck) begin
      rx_data <= {rx_data[DATA_W-2:0], miso_i};
      rx_full <= rx_full && !rx_rd_i;
    end else if (c_done_s != c_done_d) begin
      rx_data <= s_word; // stable for many sck edges after toggle
      rx_full <= 1'b1;   // new word wins over a read
    end else if (m_busy && m_tick && m_sck && (m_cnt == CNT_W'(1))) begin
      rx_full <= 1'b1;
    end else if (rx_rd_i) begin
      rx_full <= 1'b0;
    end
  end

  // slave engine on link clock; runs only while select is low
  // select and data pins belong to the link clock and need no extra flops here
  always_ff @(posedge sck_i) begin
    if (!rstn_i) begin
      s_shift    <= '0;
      s_cnt      <= '0;
      s_word     <= '0;
      s_done_tgl <= 1'b0;
      s_req_m    <= 1'b0;
      s_req_s    <= 1'b0;
      s_ack      <= 1'b0;
      s_tx       <= '0;
    end else begin
      s_req_m <= load_req;
      s_req_s <= s_req_m;
      if (!sel_n_i && !master_mode_i) begin
        s_shift <= {s_shift[DATA_W-2:0], mosi_i};
        if (s_cnt == CNT_W'(DATA_W - 1)) begin
          s_cnt      <= '0;
          s_word     <= {s_shift[DATA_W-2:0], mosi_i};
          s_done_tgl <= !s_done_tgl;
          if (s_req_s != s_ack) begin
            s_tx  <= load_word;
            s_ack <= s_req_s;
          end
        end else begin
          s_cnt <= s_cnt + 1'b1;
          s_tx  <= {s_tx[DATA_W-2:0], 1'b0};
        end
      end else begin
        s_cnt <= '0;
      end
    end
  end

  // slave output bit changes on falling edge
  // a half period of setup for the master's rising-edge sample
  always_ff @(negedge sck_i) begin
    if (!rstn_i) begin
      s_miso <= 1'b0;
    end else begin
      s_miso <= s_tx[DATA_W-1];
    end
  end

  // pins and status
  // busy covers a master shift as well as a pending slave hand-over
  assign sck_o    = m_sck;
  assign mosi_o   = m_shift[DATA_W-1];
  assign miso_o   = s_miso;
  assign cs0_n_o  = !m_cs;
  assign enabled_o                     = enabled;
  assign transmit_holding_empty_flag_o = the_flag;
  assign rx_full_o = rx_full;
  assign rx_data_o = rx_data;
  assign busy_o    = m_busy || (state != sqk_pkg::SQK_IDLE);
endmodule
`default_nettype wire

// >>> sqk_spi_chk.sv
// checker for the spi port: command effects, write filtering, start blocking
// assumes one core clock domain; bound onto every sqk_spi_port instance
`timescale 1ns/1ps
`default_nettype none
module sqk_spi_chk (
  // clock and reset
  input wire logic core_clk_i, rstn_i,
  // commands, writes and mode
  input wire logic enable_cmd_i, disable_cmd_i, soft_reset_command_i, thr_wr_i,
  input wire logic master_mode_i, fault_detect_disable_i, keep_select_after_transfer_i,
  // status and select pin
  input wire logic cs0_n_o, enabled_o, transmit_holding_empty_flag_o, busy_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // start refused: keep-select with fault detection on
  wire logic blk = keep_select_after_transfer_i && !fault_detect_disable_i;
  wire logic cmd = enable_cmd_i || disable_cmd_i || soft_reset_command_i; // any command
  wire logic thr = transmit_holding_empty_flag_o; // short alias
  AST_BLOCKED_NO_START: assert property (blk && !busy_o |=> !busy_o)
    else $error("transfer started while starts are blocked");
  AST_MASTER_START: assert property (enabled_o && master_mode_i && thr && thr_wr_i && !busy_o
    && !blk && !cmd |=> !thr ##1 (busy_o && !cs0_n_o)) else $error("accepted word did not start");
  AST_SLAVE_KEEPS_ON: assert property (enabled_o && !master_mode_i && disable_cmd_i
    && !soft_reset_command_i |=> enabled_o) else $error("slave port was disabled");
  AST_WRITE_DROPPED: assert property (!enabled_o && thr && thr_wr_i |=> thr)
    else $error("write accepted while disabled");
  AST_DISABLE_KEEPS_FLAG: assert property (disable_cmd_i && thr && !thr_wr_i |=> thr)
    else $error("disable changed the empty flag");
  AST_DISABLED_IDLE: assert property (!enabled_o && !busy_o |=> !busy_o)
    else $error("disabled port started a transfer");
  AST_SOFT_RESET: assert property (soft_reset_command_i
    |=> !enabled_o && thr && cs0_n_o && !busy_o) else $error("soft reset left state behind");
  // main scenarios reached
  cover property (enabled_o && master_mode_i && thr_wr_i ##2 busy_o);
  cover property (enabled_o && !master_mode_i && disable_cmd_i);
  cover property (blk && enabled_o && thr_wr_i);
endmodule
bind sqk_spi_port sqk_spi_chk u_sqk_spi_chk (.core_clk_i, .rstn_i, .enable_cmd_i,
  .disable_cmd_i, .soft_reset_command_i, .thr_wr_i, .master_mode_i, .fault_detect_disable_i,
  .keep_select_after_transfer_i, .cs0_n_o, .enabled_o, .transmit_holding_empty_flag_o, .busy_o);
`default_nettype wire

// >>> sqk_spi_slave_model.sv
// far-side spi slave: samples mosi on rising sck, shifts a reply out msb first
// assumes mode 0 framing and a select that is low for whole bytes
`timescale 1ns/1ps
`default_nettype none
module sqk_spi_slave_model (
  input  wire logic       sck_i,
  input  wire logic       cs_n_i,
  input  wire logic       mosi_i,
  input  wire logic [7:0] reply_i,
  output logic            miso_o,
  output logic [7:0]      got_o
);
  logic [2:0] cnt  = 3'h0; // bit position in the byte
  logic       last = 1'b0; // last bit driven
  // new frame restarts the bit count
  always @(negedge cs_n_i) cnt = 3'h0;
  // capture on the rising edge, then move to the next reply bit
  always @(posedge sck_i) if (!cs_n_i) begin
    got_o = {got_o[6:0], mosi_i};
    last  = miso_o;
    cnt   = cnt + 3'h1;
  end
  // released line shows the inverse so stale data never looks valid
  assign miso_o = cs_n_i ? ~last : reply_i[3'h7 - cnt];
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench for the spi port in master and slave use
// assumes the checker is bound and the slave model sits on the serial pins
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk = 0, rstn = 0, sck = 0, en = 0, dis = 0, srst = 0, mm = 1, fdd = 1, ksel = 0;
  logic wr = 0, rd = 0, seln = 1, mosi = 0, miso, sck_o, mosi_o, cs_n, ena, thr_e, rxf, busy;
  logic       smiso; // slave reply bit from the port
  logic [3:0] div = 4'h1;
  logic [7:0] wd = 8'h00, rxd, got;
  int error_cnt = 0, tests_run = 0;
  always #2.5 core_clk = ~core_clk;
  sqk_spi_port u_sqk_spi_port (.core_clk_i(core_clk), .rstn_i(rstn), .sck_i(sck),
    .enable_cmd_i(en), .disable_cmd_i(dis), .soft_reset_command_i(srst), .master_mode_i(mm),
    .fault_detect_disable_i(fdd), .keep_select_after_transfer_i(ksel), .clk_div_i(div),
    .thr_wr_i(wr), .thr_data_i(wd), .rx_rd_i(rd), .sel_n_i(seln), .mosi_i(mosi),
    .miso_i(miso), .sck_o(sck_o), .mosi_o(mosi_o), .miso_o(smiso), .cs0_n_o(cs_n),
    .enabled_o(ena), .transmit_holding_empty_flag_o(thr_e), .rx_full_o(rxf),
    .rx_data_o(rxd), .busy_o(busy));
  sqk_spi_slave_model u_sqk_spi_slave_model (.sck_i(sck_o), .cs_n_i(cs_n), .mosi_i(mosi_o),
    .reply_i(8'h3c), .miso_o(miso), .got_o(got));
  task automatic end_sim;
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // core-side inputs change 1 ns after the rising edge; frame pins follow the frame task's own timing
  task automatic cyc(input int n); repeat (n) @(posedge core_clk); #1; endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one-cycle command pulse: {soft reset, disable, enable}
  task automatic cmd(input logic [2:0] c);
    {srst, dis, en} = c;
    cyc(1);
    {srst, dis, en} = 3'h0;
    cyc(1);
  endtask
  task automatic put(input logic [7:0] d);
    wd = d;
    wr = 1;
    cyc(1);
    wr = 0;
    cyc(1);
  endtask
  // bounded wait for the engine to finish
  task automatic wait_idle;
    int i;
    cyc(3);
    for (i = 0; i < 400 && busy !== 1'b0; i++) cyc(1);
    if (i == 400) begin error_cnt++; end_sim; end
  endtask
  // bounded wait for a received word
  task automatic wait_rx;
    int i;
    for (i = 0; i < 100 && rxf !== 1'b1; i++) cyc(1);
    if (i == 100) begin error_cnt++; end_sim; end
  endtask
  // one link frame on the bench's own 12 ns clock, msb first; q gets the reply
  task automatic frame(input logic [7:0] d, output logic [7:0] q);
    seln = 0;
    #2;
    for (int i = 0; i < 8; i++) begin
      mosi = d[7 - i];
      #6;
      q = {q[6:0], smiso};
      sck = 1;
      #6;
      sck = 0;
    end
    #6;
    seln = 1;
    cyc(1);
  endtask
  task automatic t_disabled_write;
    put(8'ha5); cyc(2);
    chk(8'(thr_e), 8'h01);
    chk(8'(busy), 8'h00);
    $display("test disabled_write done");
  endtask
  task automatic t_master;
    cmd(3'h1); put(8'ha5); wait_idle;
    chk(got, 8'ha5);
    chk(rxd, 8'h3c);
    rd = 1; cyc(1); rd = 0; cyc(1);
    chk(8'(rxf), 8'h00);
    $display("test master done");
  endtask
  task automatic t_blocked;
    ksel = 1; fdd = 0; put(8'h5a); cyc(40);
    chk({6'h0, busy, cs_n}, 8'h01);
    fdd = 1; wait_idle;
    chk(got, 8'h5a);
    ksel = 0; cyc(2);
    $display("test blocked done");
  endtask
  task automatic t_dma_disable;
    cyc(2); cmd(3'h2);
    for (int k = 0; k < 4; k++) put(8'(k));
    cyc(2);
    chk({6'h0, thr_e, busy}, 8'h02);
    chk(got, 8'h5a);
    cmd(3'h1); put(8'hc3); wait_idle;
    chk(got, 8'hc3);
    $display("test dma_disable done");
  endtask
  task automatic t_slave;
    logic [7:0] q;
    mm = 0;
    cmd(3'h1);
    cmd(3'h2);
    chk(8'(ena), 8'h01);
    put(8'h5c);
    frame(8'h96, q);
    wait_rx;
    chk(rxd, 8'h96);
    rd = 1;
    cyc(1);
    rd = 0;
    cyc(1);
    frame(8'h69, q);
    chk(q, 8'h5c);
    wait_rx;
    chk(rxd, 8'h69);
    rd = 1;
    cyc(1);
    rd = 0;
    cmd(3'h4);
    cyc(3);
    chk({5'h0, ena, thr_e, rxf}, 8'h02);
    $display("test slave done");
  endtask
  initial begin
    // the link side resets on its own clock, so give it edges while reset is low
    fork
      cyc(20);
      repeat (2) begin
        #6 sck = 1;
        #6 sck = 0;
      end
    join
    rstn = 1;
    cyc(1);
    chk({4'h0, ena, thr_e, cs_n, sck_o}, 8'h06);
    t_disabled_write;
    t_master;
    t_blocked;
    t_dma_disable;
    t_slave;
    end_sim;
  end
endmodule
`default_nettype wire
